// file: rtl/jsrb_host.sv
// JTAG host that runs the shutdown readback tail sequence
// ------------------------------------------------------------
// Functional notes
// - After the shutdown instruction, TMS stays low in Run-Test/Idle for 12 TCK cycles.
// - The configuration-input instruction goes out as ten bits LSB first, MSB with TMS high.
// - After an instruction, TMS high two cycles then low two cycles reaches Shift-DR.
// - Packets dummy, sync, no-op, command header and restart command go MSB first.
// - Then frame-address header, start address, readout header, word count and two flushes.
// - The packet stream runs 351 cycles with TMS low and the last bit with TMS high.
// - After the packets, TMS high three cycles then low two cycles reaches Shift-IR.
// - The configuration-output instruction goes out as ten bits LSB first, MSB with TMS high.
// - Readout takes count minus one bits with TMS low and the last bit with TMS high.
// - The sequence ends with TMS high for five cycles to Test-Logic-Reset.
module jsrb_host (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // User control
    input wire logic start,
    input wire logic [15:0] dummy_frame_bits,
    output logic busy,
    output logic done,
    // Readback data
    output logic rd_valid,
    output logic rd_bit,
    // JTAG pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    import jsrb_pkg::*;
    // ------------------------------------------------------------
    // Packet stream and derived lengths
    // ------------------------------------------------------------
    localparam logic [PKT_BITS-1:0] PKT_STREAM = {PKT_DUMMY, PKT_SYNC, PKT_NOOP,
        PKT_CMD_HDR, PKT_RESTART, PKT_FAR_HDR, PKT_FAR_ADDR, PKT_FRAME_READOUT_REGISTER_HDR,
        PKT_WCNT_HDR, PKT_FLUSH, PKT_FLUSH};
    localparam logic [26:0] RD_WORDS = PKT_WCNT_HDR[26:0] & WCNT_MASK;
    localparam logic [31:0] RD_BITS = 32'(RD_WORDS) * 32'(WORD_BITS);
    localparam logic [31:0] RD_LOW_BITS = RD_BITS - 32'd1;
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    jsrb_state_type st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [8:0] pix_q, pix_d;
    logic [31:0] rdn_q;
    logic tms_q, tms_d, tdi_q, tdi_d;
    logic busy_q, done_q, rv_q, rb_q;
    logic tck_w, fall_w, rise_w, tdo_s;
    jsrb_tck_gen u_tck (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(busy_q),
        .fall_stb(fall_w),
        .rise_stb(rise_w),
        .tck(tck_w)
    );
    jsrb_sync u_tdo (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(tdo),
        .dout(tdo_s)
    );
    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    // Each state other than ST_IDLE lasts a fixed number of TCK falls; cnt counts them down
    wire last = (cnt_q == 32'd1);
    wire [8:0] pkt_idx = 9'(PKT_BITS - 1) - pix_q;
    wire pkt_bit = PKT_STREAM[pkt_idx];
    wire ir1_bit = CFG_IN_INSTR[pix_q[3:0]];
    wire ir2_bit = CFG_OUT_INSTR[pix_q[3:0]];
    // Sample TDO on the rising edge of TCK during readout shift cycles
    wire rd_take = rise_w && (st_q == ST_RDO);
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        pix_d = pix_q;
        tms_d = tms_q;
        tdi_d = tdi_q;
        if (st_q == ST_IDLE) begin
            if (start) begin
                st_d = ST_RTI;
                cnt_d = 32'(RTI_SHUTDOWN_CYC);
                tms_d = 1'b0;
                tdi_d = 1'b0;
            end
        end else if (fall_w) begin
            cnt_d = cnt_q - 32'd1;
            pix_d = pix_q + 9'd1;
            case (st_q)
                ST_RTI: if (last) begin
                    st_d = ST_SIR1_HI; cnt_d = 32'(TMS_HI_2); tms_d = 1'b1;
                end
                ST_SIR1_HI: if (last) begin
                    st_d = ST_SIR1_LO; cnt_d = 32'(TMS_LO_2); tms_d = 1'b0;
                end
                ST_SIR1_LO: if (last) begin
                    st_d = ST_IR1; cnt_d = 32'(IR_LOW_BITS) + 32'd1; pix_d = 9'd0;
                    tdi_d = CFG_IN_INSTR[0];
                end
                ST_IR1: begin
                    tdi_d = CFG_IN_INSTR[pix_d[3:0]];
                    tms_d = (cnt_q == 32'd2);
                    if (last) begin
                        // Exit bit lands in Exit1-IR; two more highs reach Select-DR
                        st_d = ST_SDR1_HI; cnt_d = 32'(TMS_HI_2); tms_d = 1'b1;
                        tdi_d = 1'b0;
                    end
                end
                ST_SDR1_HI: if (last) begin
                    st_d = ST_SDR1_LO; cnt_d = 32'(TMS_LO_2); tms_d = 1'b0;
                end
                ST_SDR1_LO: if (last) begin
                    st_d = ST_PKT; cnt_d = 32'(PKT_LOW_BITS) + 32'd1; pix_d = 9'd0;
                    tdi_d = PKT_STREAM[PKT_BITS-1];
                end
                ST_PKT: begin
                    tdi_d = PKT_STREAM[9'(PKT_BITS - 1) - pix_d];
                    tms_d = (cnt_q == 32'd2);
                    if (last) begin
                        st_d = ST_SIR2_HI; cnt_d = 32'(TMS_HI_3); tms_d = 1'b1;
                        tdi_d = 1'b0;
                    end
                end
                ST_SIR2_HI: if (last) begin
                    st_d = ST_SIR2_LO; cnt_d = 32'(TMS_LO_2); tms_d = 1'b0;
                end
                ST_SIR2_LO: if (last) begin
                    st_d = ST_IR2; cnt_d = 32'(IR_LOW_BITS) + 32'd1; pix_d = 9'd0;
                    tdi_d = CFG_OUT_INSTR[0];
                end
                ST_IR2: begin
                    tdi_d = CFG_OUT_INSTR[pix_d[3:0]];
                    tms_d = (cnt_q == 32'd2);
                    if (last) begin
                        st_d = ST_SDR2_HI; cnt_d = 32'(TMS_HI_2); tms_d = 1'b1;
                        tdi_d = 1'b0;
                    end
                end
                ST_SDR2_HI: if (last) begin
                    st_d = ST_SDR2_LO; cnt_d = 32'(TMS_LO_2); tms_d = 1'b0;
                end
                ST_SDR2_LO: if (last) begin
                    st_d = ST_RDO; cnt_d = RD_LOW_BITS + 32'd1; tdi_d = 1'b0;
                end
                ST_RDO: begin
                    tms_d = (cnt_q == 32'd2);
                    if (last) begin
                        st_d = ST_SIR3; cnt_d = 32'(TMS_HI_3) + 32'(TMS_LO_2);
                        tms_d = 1'b1;
                    end
                end
                ST_SIR3: begin
                    tms_d = (cnt_q > 32'd3);
                    if (last) begin
                        st_d = ST_TLR; cnt_d = 32'(TLR_CYC); tms_d = 1'b1;
                    end
                end
                ST_TLR: if (last) begin
                    st_d = ST_IDLE; cnt_d = 32'd0;
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 32'd0;
            pix_q <= 9'd0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pix_q <= pix_d;
            tms_q <= tms_d;
            tdi_q <= tdi_d;
        end
    end
    // Leading frame bits are dropped before reaching the user stream
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rv_q <= 1'b0;
            rb_q <= 1'b0;
            rdn_q <= 32'd0;
        end else begin
            busy_q <= (st_d != ST_IDLE);
            done_q <= (st_q == ST_TLR) && (st_d == ST_IDLE);
            rv_q <= rd_take && (rdn_q >= 32'(dummy_frame_bits));
            rb_q <= tdo_s;
            rdn_q <= (st_q == ST_IDLE) ? 32'd0 : (rd_take ? rdn_q + 32'd1 : rdn_q);
        end
    end
    logic tck_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tck_q <= 1'b0;
        end else begin
            tck_q <= tck_w;
        end
    end
    assign tck = tck_q;
    assign tms = tms_q;
    assign tdi = tdi_q;
    assign busy = busy_q;
    assign done = done_q;
    assign rd_valid = rv_q;
    assign rd_bit = rb_q;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_enter_rti;
        (st_q == ST_IDLE) && start;
    endsequence
    a_rti_tms_low: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_RTI) |-> !tms_q)
        else $error("TMS high during shutdown wait");
    a_start_rti: assert property (@(posedge clk) disable iff (sys_rst)
        s_enter_rti |=> (st_q == ST_RTI) && (cnt_q == 32'd12))
        else $error("shutdown wait not armed for 12 cycles");
    a_ir1_exit_tms: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_IR1) && fall_w && (cnt_q == 32'd2) |=> tms_q && tdi_q)
        else $error("CFG in instruction MSB not shifted on exit");
    a_sdr_entry: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_SDR1_LO) |-> !tms_q)
        else $error("TMS not low on the way to Shift-DR");
    a_pkt_first: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_SDR1_LO) && fall_w && last |=> (tdi_q == PKT_STREAM[PKT_BITS-1]))
        else $error("packet stream does not start with its MSB");
    a_pkt_len: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_PKT) && fall_w && last |=> (st_q == ST_SIR2_HI)
        ##0 $past(pix_q) == 9'd351)
        else $error("packet stream length wrong");
    a_ir1_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_IR1) && !tms_q |-> (tdi_q == ir1_bit))
        else $error("CFG in instruction bit wrong");
    a_pkt_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_PKT) && !tms_q |-> (tdi_q == pkt_bit))
        else $error("packet stream bit wrong");
    a_ir2_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_IR2) && !tms_q |-> (tdi_q == ir2_bit))
        else $error("CFG out instruction bit wrong");
    a_rdo_tms: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_RDO) && (cnt_q > 32'd1) |-> !tms_q)
        else $error("TMS high before last readout bit");
    a_tlr_tms: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ST_TLR) |-> tms_q)
        else $error("TMS low during final reset");
endmodule

// file: rtl/jsrb_pkg.sv
// Constants and types shared by the shutdown readback sequencer
package jsrb_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    // Fast enough that a whole readback fits a short regression
    localparam int TCK_HZ = 2500000;
    localparam int TCK_HALF_CYC = CLK_HZ / (2 * TCK_HZ);
    localparam logic [7:0] TCK_HALF_LAST = 8'(TCK_HALF_CYC - 1);
    // ------------------------------------------------------------
    // Sequence counts, in TCK cycles
    // ------------------------------------------------------------
    localparam logic [15:0] RTI_SHUTDOWN_CYC = 16'd12;
    localparam logic [15:0] TMS_HI_2 = 16'd2;
    localparam logic [15:0] TMS_LO_2 = 16'd2;
    localparam logic [15:0] TMS_HI_3 = 16'd3;
    localparam logic [15:0] IR_LOW_BITS = 16'd9;
    localparam logic [15:0] PKT_LOW_BITS = 16'd351;
    localparam logic [15:0] TLR_CYC = 16'd5;
    localparam int PKT_WORDS = 11;
    localparam int PKT_BITS = 352;
    // ------------------------------------------------------------
    // Instructions, ten bits, shifted LSB first
    // ------------------------------------------------------------
    localparam logic [9:0] CFG_IN_INSTR = 10'h3C5;
    localparam logic [9:0] CFG_OUT_INSTR = 10'h3C4;
    // ------------------------------------------------------------
    // Packet stream, first word first, each word MSB first
    // ------------------------------------------------------------
    localparam logic [31:0] PKT_DUMMY = 32'h0FFFFFFF;
    localparam logic [31:0] PKT_SYNC = 32'hAA995566;
    localparam logic [31:0] PKT_NOOP = 32'h02000000;
    localparam logic [31:0] PKT_CMD_HDR = 32'h30008001;
    localparam logic [31:0] PKT_RESTART = 32'h00000004;
    localparam logic [31:0] PKT_FAR_HDR = 32'h30002001;
    localparam logic [31:0] PKT_FAR_ADDR = 32'h00000000;
    localparam logic [31:0] PKT_FRAME_READOUT_REGISTER_HDR = 32'h28006000;
    localparam logic [31:0] PKT_WCNT_HDR = 32'h48024090;
    localparam logic [31:0] PKT_FLUSH = 32'h20000000;
    // Only the low count field is used: 0x090 words for this header
    localparam logic [26:0] WCNT_MASK = 27'h0000FFF;
    localparam int WORD_BITS = 32;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_IDLE = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SIR1_HI = 16'h0004,
        ST_SIR1_LO = 16'h0008,
        ST_IR1 = 16'h0010,
        ST_SDR1_HI = 16'h0020,
        ST_SDR1_LO = 16'h0040,
        ST_PKT = 16'h0080,
        ST_SIR2_HI = 16'h0100,
        ST_SIR2_LO = 16'h0200,
        ST_IR2 = 16'h0400,
        ST_SDR2_HI = 16'h0800,
        ST_SDR2_LO = 16'h1000,
        ST_RDO = 16'h2000,
        ST_SIR3 = 16'h4000,
        ST_TLR = 16'h8000
    } jsrb_state_type;
endpackage

// file: rtl/jsrb_sync.sv
// Two-flop synchroniser for the TDO pin
module jsrb_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Asynchronous input and result
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule

// file: rtl/jsrb_tck_gen.sv
// TCK divider: clock output that runs only while run is high, plus edge strobes
module jsrb_tck_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    // Strobes and clock
    output logic fall_stb,
    output logic rise_stb,
    output logic tck
);
    import jsrb_pkg::*;
    logic [7:0] cnt_q;
    logic tck_q;
    wire half_done = (cnt_q == TCK_HALF_LAST);
    // TCK stands low while idle so the TAP sees no stray edges
    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            cnt_q <= 8'h00;
            tck_q <= 1'b0;
        end else if (half_done) begin
            cnt_q <= 8'h00;
            tck_q <= ~tck_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign rise_stb = run && half_done && !tck_q;
    assign fall_stb = run && half_done && tck_q;
    assign tck = tck_q;
endmodule

// file: sim/jsrb_tap_model.sv
// Boundary-scan device model: TAP, instruction register, packet and readout registers
module jsrb_tap_model (
    // JTAG pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    // Device pin and observation
    output logic cfg_done,
    output logic [7:0] rti_cycles,
    output logic [19:0] ir_hist,
    output logic [351:0] pkt_bits,
    output logic [15:0] pkt_len,
    output logic [15:0] rd_len,
    output logic [3:0] tap_st
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // TAP next state, one nibble per state, for TMS low and high
    // ------------------------------------------------------------
    localparam logic [63:0] NX_LO = 64'h1BDDBBA146644311;
    localparam logic [63:0] NX_HI = 64'h2FEFCC0287855920;
    localparam logic [9:0] SHUT_IR = 10'h3C6;
    logic [9:0] ir_sh;
    logic [9:0] ir_q;
    logic [3:0] st_nx;
    logic [3:0] ir_n;
    initial begin
        // Sequence starts with shutdown loaded and the TAP in Run-Test/Idle
        ir_q = SHUT_IR;
        tap_st = 4'h1;
        ir_sh = 10'h000;
        ir_n = 4'h0;
        tdo = 1'b0;
        rti_cycles = 8'h00;
        ir_hist = 20'h00000;
        pkt_len = 16'h0000;
        rd_len = 16'h0000;
    end
    assign st_nx = tms ? NX_HI[tap_st * 4 +: 4] : NX_LO[tap_st * 4 +: 4];
    assign cfg_done = !(ir_q == SHUT_IR && tap_st == 4'h1 && rti_cycles < 8'h0C);
    always @(posedge tck) begin
        if (tap_st == 4'h1 && ir_q == SHUT_IR && !tms) begin
            rti_cycles <= rti_cycles + 8'h01;
        end
        if (tap_st == 4'hA) begin
            ir_n <= 4'h0;
        end
        if (tap_st == 4'hB) begin
            ir_sh <= {tdi, ir_sh[9:1]};
            ir_n <= ir_n + 4'h1;
        end
        // Passing Update-IR on the way to reset is not a full instruction
        if (st_nx == 4'hF) begin
            ir_q <= ir_sh;
            if (ir_n == 4'hA) begin
                ir_hist <= {ir_hist[9:0], ir_sh};
            end
        end
        if (tap_st == 4'h4 && ir_q == 10'h3C5) begin
            pkt_bits <= {pkt_bits[350:0], tdi};
            pkt_len <= pkt_len + 16'h0001;
        end
        if (tap_st == 4'h4 && ir_q == 10'h3C4) begin
            rd_len <= rd_len + 16'h0001;
        end
        tap_st <= st_nx;
    end
    // Unselected TDO flips every fall so a stale bit never looks valid
    always @(negedge tck) begin
        if (tap_st == 4'h4 && ir_q == 10'h3C4) begin
            tdo <= rd_len[0] ^ rd_len[5] ^ rd_len[9];
        end else begin
            tdo <= !tdo;
        end
    end
endmodule

// file: sim/tb_jsrb_host.sv
// Self-checking bench for the shutdown readback host sequencer
module tb_jsrb_host;
    timeunit 1ns;
    timeprecision 1ps;
    import jsrb_pkg::*;
    // One discarded frame; readout length is fixed by the header, so the run is ~50k clocks
    localparam logic [15:0] DUMMY_BITS = 16'h0520;
    localparam int RD_BITS = 4608;
    localparam logic [351:0] EXP_PKT = {32'h0FFFFFFF, 32'hAA995566, 32'h02000000,
        32'h30008001, 32'h00000004, 32'h30002001, 32'h00000000, 32'h28006000,
        32'h48024090, 32'h20000000, 32'h20000000};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [15:0] frame_bits = DUMMY_BITS;
    logic busy, done, rd_valid, rd_bit, tck, tms, tdi, tdo, cfg_done;
    logic [7:0] rti_cycles;
    logic [19:0] ir_hist;
    logic [351:0] pkt_bits;
    logic [15:0] pkt_len, rd_len;
    logic [3:0] tap_st;
    int err_count = 0;
    int n_checks = 0;
    int kept = 0;
    jsrb_host i_jsrb_host (.clk(clk), .sys_rst(sys_rst), .start(start),
        .dummy_frame_bits(frame_bits), .busy(busy), .done(done), .rd_valid(rd_valid),
        .rd_bit(rd_bit), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    jsrb_tap_model i_jsrb_tap_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .cfg_done(cfg_done), .rti_cycles(rti_cycles), .ir_hist(ir_hist),
        .pkt_bits(pkt_bits), .pkt_len(pkt_len), .rd_len(rd_len), .tap_st(tap_st));
    always #20 clk = ~clk;
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic pat(input int k);
        return k[0] ^ k[5] ^ k[9];
    endfunction
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            check_val(32'(rd_bit), 32'(pat(int'(DUMMY_BITS) + kept)), "kept bit");
            kept++;
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_idle;
        @(negedge clk);
        check_val({28'h0, tck, tms, busy, done}, 32'h4, "idle pins");
    endtask
    task automatic t_run;
        int n;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        @(negedge clk);
        check_val(32'(busy), 32'h1, "busy after start");
        check_val(32'(cfg_done), 32'h0, "complete low in shutdown");
        repeat (3000) @(posedge clk);
        // A second start mid-run must not restart the sequence
        start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        for (n = 0; n < 70000 && done !== 1'b1; n++) begin
            @(negedge clk);
        end
        check_val(32'(done), 32'h1, "done seen");
        @(negedge clk);
        check_val({30'h0, done, busy}, 32'h0, "done one cycle");
    endtask
    task automatic t_shutdown_wait;
        check_val(32'(rti_cycles), 32'd12, "idle wait cycles");
    endtask
    task automatic t_instr;
        check_val(32'(ir_hist), {12'h0, 10'h3C5, 10'h3C4}, "instructions");
    endtask
    task automatic t_packets;
        int i;
        check_val(32'(pkt_len), 32'd352, "packet bits");
        for (i = 0; i < 11; i++) begin
            check_val(pkt_bits[351 - 32 * i -: 32], EXP_PKT[351 - 32 * i -: 32], "word");
        end
    endtask
    task automatic t_readout;
        check_val(32'(rd_len), 32'(RD_BITS), "readout bits");
        check_val(32'(kept), 32'(RD_BITS - int'(DUMMY_BITS)), "kept count");
    endtask
    task automatic t_end;
        check_val(32'(tap_st), 32'h0, "tap in reset");
        check_val({30'h0, tck, tms}, 32'h1, "pins idle");
        check_val(32'(cfg_done), 32'h1, "complete high after shutdown");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_idle();
        t_run();
        t_shutdown_wait();
        t_instr();
        t_packets();
        t_readout();
        t_end();
        end_of_test();
    end
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
